/* File: rtl/status_cmd_defines.vh */
// How it works
// RL1: Recall 0 restores whole configuration from slot
// RL2: Exactly one setup slot for save/recall
// RL3: Recall error reloads slot with preset defaults
// RL4: Slot starts holding preset defaults
// RL5: Reset: defaults, cancel pending, cancel completion
// RL6: Save 0 copies reset-affected controls into slot
// RL7: Enable write is bit pattern, 0/255
// RL8: Enable bits 0,2,3,4,5,7 only
// RL9: Enable mask zero at power-up
// RL10: Service request when enabled status bit set
// RL11: Enable mask readable by query
// RL12: Status query returns byte, changes nothing
// RL13: Summary bits follow their sources only
// RL14: Bit 6 set on enabled summary condition
// RL15: Bit 2 means error queue nonempty
// RL16: Bit 4 means output message waiting
// RL17: Bit 5 summarises standard events
// RL18: Bit 7 summarises operation events
// RL19: Bit 3 is questionable summary
// RL20: Bit 0 measurement summary, bit 1 unused
// RL21: Bus trigger acts only on bus source
// RL22: Self-test answers 0 pass, 1 fail
// RL23: Bit 6 is OR of enabled summaries
`ifndef STATUS_CMD_DEFINES_VH
`define STATUS_CMD_DEFINES_VH
`define CMD_NONE       4'h0
`define CMD_RECALL     4'h1
`define CMD_RESET      4'h2
`define CMD_SAVE       4'h3
`define CMD_SRE_WRITE  4'h4
`define CMD_SRE_QUERY  4'h5
`define CMD_STB_QUERY  4'h6
`define CMD_TRIGGER    4'h7
`define CMD_SELFTEST   4'h8
`define BIT_MEAS       0
`define BIT_ERRQ       2
`define BIT_QUES       3
`define BIT_MSG        4
`define BIT_STDEV      5
`define BIT_MSS        6
`define BIT_OPER       7
`define SRE_IMPL_MASK  8'hBD
`define SRE_RESET      8'h00
`define TRIG_SRC_BUS   2'h1
`define RESP_PASS      8'h00
`define RESP_FAIL      8'h01
`endif

/* File: rtl/rom_checksum.v */
`timescale 1ns/1ps
`default_nettype none
// Sums a word-addressed ROM; result compared with expected sum
module rom_checksum #(
    parameter AW = 4,
    parameter [7:0] EXPECTED = 8'h00
)(
    input  wire          clk_i,
    input  wire          resetn_i,
    input  wire          start_i,
    input  wire [7:0]    rom_data_i,
    output reg  [AW-1:0] rom_addr_o,
    output reg           done_o,
    output reg           fail_o
);
    reg [7:0] sum_ff;
    reg       busy_ff;
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sum_ff     <= 8'h00;
            busy_ff    <= 1'b0;
            rom_addr_o <= {AW{1'b0}};
            done_o     <= 1'b0;
            fail_o     <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i && !busy_ff)
            begin
                busy_ff    <= 1'b1;
                sum_ff     <= 8'h00;
                rom_addr_o <= {AW{1'b0}};
            end
            else if (busy_ff)
            begin
                sum_ff     <= sum_ff + rom_data_i;
                rom_addr_o <= rom_addr_o + {{(AW-1){1'b0}}, 1'b1};
                if (&rom_addr_o)
                begin
                    busy_ff <= 1'b0;
                    done_o  <= 1'b1;
                    fail_o  <= ((sum_ff + rom_data_i) != EXPECTED); // [RL22]
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/setup_store.v */
`timescale 1ns/1ps
`default_nettype none
// Single setup slot; a checksum byte guards against corrupt recall
module setup_store #(
    parameter W = 16,
    parameter [W-1:0] PRESET = 16'h0000
)(
    input  wire         clk_i,
    input  wire         resetn_i,
    input  wire         save_i,
    input  wire         recall_i,
    input  wire [W-1:0] live_i,
    output reg  [W-1:0] slot_o,
    output reg          recall_err_o
);
    reg [7:0] guard_ff;
    function [7:0] fold;
        input [W-1:0] v;
        integer k;
        begin
            fold = 8'hA5;
            for (k = 0; k < W; k = k + 1)
                fold[k % 8] = fold[k % 8] ^ v[k];
        end
    endfunction
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            slot_o       <= PRESET; // [RL4]
            guard_ff     <= fold(PRESET);
            recall_err_o <= 1'b0;
        end
        else
        begin
            recall_err_o <= 1'b0;
            if (save_i)
            begin
                slot_o   <= live_i; // [RL2] [RL6]
                guard_ff <= fold(live_i);
            end
            else if (recall_i && fold(slot_o) != guard_ff)
            begin
                slot_o       <= PRESET; // [RL3]
                guard_ff     <= fold(PRESET);
                recall_err_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/status_byte_cmds.v */
`timescale 1ns/1ps
`default_nettype none
`include "status_cmd_defines.vh"
module status_byte_cmds #(
    parameter CFG_W = 16,
    parameter [CFG_W-1:0] RESET_CFG  = 16'h0000,
    parameter [CFG_W-1:0] PRESET_CFG = 16'h0000,
    parameter ROM_AW = 4,
    parameter [7:0] ROM_SUM = 8'h00
)(
    input  wire             clk_i,
    input  wire             resetn_i,
    input  wire             cmd_valid_i,
    input  wire [3:0]       cmd_code_i,
    input  wire [7:0]       cmd_param_i,
    input  wire [1:0]       trig_source_i,
    input  wire             meas_summary_i,
    input  wire             error_queue_nonempty_i,
    input  wire             questionable_summary_i,
    input  wire             output_message_waiting_i,
    input  wire             standard_event_summary_i,
    input  wire             operation_summary_i,
    input  wire [7:0]       rom_data_i,
    input  wire             serial_poll_i,
    output wire [ROM_AW-1:0] rom_addr_o,
    output reg  [CFG_W-1:0] config_o,
    output reg              cancel_pending_o,
    output reg              cancel_opc_o,
    output reg              trigger_o,
    output reg              resp_valid_o,
    output reg  [7:0]       resp_data_o,
    output reg              srq_o,
    output reg              request_service_flag_o,
    output reg              busy_o
);
    localparam ST_IDLE    = 2'd0;
    localparam ST_RECALL  = 2'd1;
    localparam ST_TEST    = 2'd2;
    localparam ST_RST2    = 2'd3;

    reg  [1:0]       state_ff;
    reg  [7:0]       service_request_enable_mask_ff;
    reg              save_ff;
    reg              recall_ff;
    reg              test_start_ff;
    wire [CFG_W-1:0] slot;
    wire             recall_err;
    wire             test_done;
    wire             test_fail;
    wire [7:0]       status_summary_byte;
    wire             master_summary_flag;

    // Bits follow live sources so clearing a source clears the bit [RL13]
    assign status_summary_byte[`BIT_MEAS]  = meas_summary_i;            // [RL20]
    assign status_summary_byte[1]          = 1'b0;                      // [RL20]
    assign status_summary_byte[`BIT_ERRQ]  = error_queue_nonempty_i;    // [RL15]
    assign status_summary_byte[`BIT_QUES]  = questionable_summary_i;    // [RL19]
    assign status_summary_byte[`BIT_MSG]   = output_message_waiting_i;  // [RL16]
    assign status_summary_byte[`BIT_STDEV] = standard_event_summary_i;  // [RL17]
    assign status_summary_byte[`BIT_OPER]  = operation_summary_i;       // [RL18]
    assign master_summary_flag =
        |(status_summary_byte & service_request_enable_mask_ff & `SRE_IMPL_MASK); // [RL23]
    assign status_summary_byte[`BIT_MSS]   = master_summary_flag;       // [RL14]

    setup_store #(
        .W      (CFG_W),
        .PRESET (PRESET_CFG)
    ) u_store (
        .clk_i        (clk_i),
        .resetn_i     (resetn_i),
        .save_i       (save_ff),
        .recall_i     (recall_ff),
        .live_i       (config_o),
        .slot_o       (slot),
        .recall_err_o (recall_err)
    );

    rom_checksum #(
        .AW       (ROM_AW),
        .EXPECTED (ROM_SUM)
    ) u_rom (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .start_i    (test_start_ff),
        .rom_data_i (rom_data_i),
        // Counter flop drives the pin directly so ROM data lines up with the sum
        .rom_addr_o (rom_addr_o),
        .done_o     (test_done),
        .fail_o     (test_fail)
    );

    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_ff                       <= ST_IDLE;
            service_request_enable_mask_ff <= `SRE_RESET; // [RL9]
            save_ff                        <= 1'b0;
            recall_ff                      <= 1'b0;
            test_start_ff                  <= 1'b0;
            config_o                       <= RESET_CFG;
            cancel_pending_o               <= 1'b0;
            cancel_opc_o                   <= 1'b0;
            trigger_o                      <= 1'b0;
            resp_valid_o                   <= 1'b0;
            resp_data_o                    <= 8'h00;
            srq_o                          <= 1'b0;
            request_service_flag_o         <= 1'b0;
            busy_o                         <= 1'b0;
        end
        else
        begin
            save_ff          <= 1'b0;
            recall_ff        <= 1'b0;
            test_start_ff    <= 1'b0;
            cancel_pending_o <= 1'b0;
            cancel_opc_o     <= 1'b0;
            trigger_o        <= 1'b0;
            resp_valid_o     <= 1'b0;
            srq_o            <= master_summary_flag; // [RL10]
            // Flag follows the summary while the poll is high and holds once the poll drops
            if (serial_poll_i)
                request_service_flag_o <= master_summary_flag; // [RL14]
            case (state_ff)
            ST_IDLE:
            begin
                busy_o <= 1'b0;
                // Busy lingers one cycle after a long command; refuse then too
                if (cmd_valid_i && !busy_o)
                begin
                    case (cmd_code_i)
                    `CMD_RECALL:
                        if (cmd_param_i == 8'h00)
                        begin
                            recall_ff <= 1'b1;
                            busy_o    <= 1'b1;
                            state_ff  <= ST_RECALL;
                        end
                    `CMD_SAVE:
                        if (cmd_param_i == 8'h00)
                            save_ff <= 1'b1; // [RL6]
                    `CMD_RESET:
                    begin
                        config_o <= RESET_CFG; // [RL5]
                        busy_o   <= 1'b1;
                        state_ff <= ST_RST2;
                    end
                    `CMD_SRE_WRITE:
                        service_request_enable_mask_ff <= cmd_param_i & `SRE_IMPL_MASK; // [RL7] [RL8]
                    `CMD_SRE_QUERY:
                    begin
                        resp_valid_o <= 1'b1;
                        resp_data_o  <= service_request_enable_mask_ff; // [RL11]
                    end
                    `CMD_STB_QUERY:
                    begin
                        resp_valid_o <= 1'b1;
                        resp_data_o  <= status_summary_byte; // [RL12]
                    end
                    `CMD_TRIGGER:
                        trigger_o <= (trig_source_i == `TRIG_SRC_BUS); // [RL21]
                    `CMD_SELFTEST:
                    begin
                        test_start_ff <= 1'b1;
                        busy_o        <= 1'b1;
                        state_ff      <= ST_TEST;
                    end
                    default:
                        busy_o <= 1'b0;
                    endcase
                end
            end
            ST_RECALL:
            begin
                // Slot settles one cycle after the check; preset if corrupt
                if (!recall_ff)
                begin
                    config_o <= recall_err ? PRESET_CFG : slot; // [RL1] [RL3]
                    state_ff <= ST_IDLE;
                end
            end
            ST_RST2:
            begin
                // Pending commands cancelled before completion responses
                if (!cancel_pending_o && !cancel_opc_o)
                    cancel_pending_o <= 1'b1; // [RL5]
                else if (cancel_pending_o)
                begin
                    cancel_opc_o <= 1'b1; // [RL5]
                    state_ff     <= ST_IDLE;
                end
            end
            ST_TEST:
            begin
                if (test_done)
                begin
                    resp_valid_o <= 1'b1;
                    resp_data_o  <= test_fail ? `RESP_FAIL : `RESP_PASS; // [RL22]
                    state_ff     <= ST_IDLE;
                end
            end
            default:
                state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: dv/rom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rom_model #(
    parameter AW = 2
)(
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          bad_i,
    output logic [7:0]         data_o
);
    // Bytes 1,4,7,10; bad_i corrupts only word 0 so the sum really changes
    assign data_o = ({{(8-AW){1'b0}}, addr_i} * 8'h03 + 8'h01)
                    ^ {7'h00, bad_i && addr_i == '0};
endmodule
`default_nettype wire

/* File: dv/status_byte_cmds_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "status_cmd_defines.vh"
module status_byte_cmds_monitor #(
    parameter CFG_W = 16,
    parameter [CFG_W-1:0] RESET_CFG = 16'h0000
)(
    input wire             clk_i,
    input wire             resetn_i,
    input wire             cmd_valid_i,
    input wire [3:0]       cmd_code_i,
    input wire [7:0]       cmd_param_i,
    input wire [1:0]       trig_source_i,
    input wire             meas_summary_i,
    input wire             error_queue_nonempty_i,
    input wire             questionable_summary_i,
    input wire             output_message_waiting_i,
    input wire             standard_event_summary_i,
    input wire             operation_summary_i,
    input wire [CFG_W-1:0] config_o,
    input wire             cancel_pending_o,
    input wire             cancel_opc_o,
    input wire             trigger_o,
    input wire             resp_valid_o,
    input wire [7:0]       resp_data_o,
    input wire             srq_o,
    input wire             busy_o
);
    logic [7:0] mask_ff;
    logic [7:0] raw;
    logic       master_summary_flag;
    logic       take;
    assign take = cmd_valid_i && !busy_o;
    assign raw = {operation_summary_i, 1'b0, standard_event_summary_i,
                  output_message_waiting_i, questionable_summary_i,
                  error_queue_nonempty_i, 1'b0, meas_summary_i};
    assign master_summary_flag = |(raw & mask_ff);
    // Shadow of the enable mask, so the summary can be predicted from ports
    always @(posedge clk_i or negedge resetn_i)
        if (!resetn_i)
            mask_ff <= 8'h00;
        else if (take && cmd_code_i == `CMD_SRE_WRITE)
            mask_ff <= cmd_param_i & 8'hbd;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    srq_follow_a: assert property (
        srq_o == $past(master_summary_flag)) else $error("srq wrong");
    sre_read_a: assert property (
        take && cmd_code_i == `CMD_SRE_QUERY |=> resp_valid_o && resp_data_o == $past(mask_ff))
        else $error("mask readback wrong");
    stb_read_a: assert property (
        take && cmd_code_i == `CMD_STB_QUERY |=> resp_valid_o
        && resp_data_o == $past(raw | {1'b0, master_summary_flag, 6'h00}))
        else $error("status byte wrong");
    trig_bus_a: assert property (
        take && cmd_code_i == `CMD_TRIGGER && trig_source_i == `TRIG_SRC_BUS |=> trigger_o)
        else $error("trigger missing");
    trig_cause_a: assert property (
        trigger_o |-> $past(take && cmd_code_i == `CMD_TRIGGER
        && trig_source_i == `TRIG_SRC_BUS)) else $error("stray trigger");
    reset_seq_a: assert property (
        take && cmd_code_i == `CMD_RESET |=> config_o == RESET_CFG
        ##1 cancel_pending_o ##1 cancel_opc_o) else $error("reset order wrong");
    selftest_a: assert property (
        take && cmd_code_i == `CMD_SELFTEST |-> ##[1:40] resp_valid_o && resp_data_o <= 8'h01)
        else $error("self-test answer missing");
    recall_skip_a: assert property (
        take && cmd_code_i == `CMD_RECALL && cmd_param_i != 8'h00 |=> $stable(config_o) [*2])
        else $error("bad recall acted");
    cover property (take && cmd_code_i == `CMD_SRE_WRITE);
    cover property (take && cmd_code_i == `CMD_STB_QUERY && master_summary_flag);
    cover property (resp_valid_o && resp_data_o == 8'h01);
endmodule
bind status_byte_cmds status_byte_cmds_monitor #(
    .CFG_W(CFG_W), .RESET_CFG(RESET_CFG)) mon (.*);
`default_nettype wire

/* File: dv/status_byte_cmds_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "status_cmd_defines.vh"
module status_byte_cmds_tb;
    localparam [15:0] RST_CFG = 16'h5a5a;
    localparam [15:0] PRE_CFG = 16'h1234;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        cmd_valid_i = 1'b0;
    logic [3:0]  cmd_code_i = 4'h0;
    logic [7:0]  cmd_param_i = 8'h00;
    logic [1:0]  trig_source_i = 2'h0;
    logic [7:0]  st = 8'h00;
    logic        poll = 1'b0;
    logic        bad = 1'b0;
    logic [1:0]  rom_addr;
    logic [7:0]  rom_data;
    logic [15:0] config_o;
    logic [7:0]  resp_data_o;
    logic        cancel_pending_o, cancel_opc_o, trigger_o, resp_valid_o, srq_o, request_service_flag, busy_o;
    logic [7:0]  pats [9] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h80, 8'hff, 8'h42};
    int          error_cnt = 0;
    int          checks = 0;
    int          i;
    always #2.5 clk_i = ~clk_i;
    rom_model #(.AW(2)) rom (.addr_i(rom_addr), .bad_i(bad), .data_o(rom_data));
    status_byte_cmds #(.CFG_W(16), .RESET_CFG(RST_CFG), .PRESET_CFG(PRE_CFG),
        .ROM_AW(2), .ROM_SUM(8'h16)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
        .cmd_code_i(cmd_code_i), .cmd_param_i(cmd_param_i), .trig_source_i(trig_source_i),
        .meas_summary_i(st[0]), .error_queue_nonempty_i(st[2]),
        .questionable_summary_i(st[3]), .output_message_waiting_i(st[4]),
        .standard_event_summary_i(st[5]), .operation_summary_i(st[7]),
        .rom_data_i(rom_data), .serial_poll_i(poll), .rom_addr_o(rom_addr),
        .config_o(config_o), .cancel_pending_o(cancel_pending_o),
        .cancel_opc_o(cancel_opc_o), .trigger_o(trigger_o), .resp_valid_o(resp_valid_o),
        .resp_data_o(resp_data_o), .srq_o(srq_o), .request_service_flag_o(request_service_flag),
        .busy_o(busy_o));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask
    // Waits out a multi-cycle command, since requests during busy are dropped
    task automatic idle;
        for (int k = 0; k < 100 && busy_o !== 1'b0; k++)
            tick();
    endtask
    task automatic cmd(input logic [3:0] c, input logic [7:0] p);
        // An edge with valid low parts back-to-back commands
        tick();
        idle();
        cmd_valid_i = 1'b1;
        cmd_code_i = c;
        cmd_param_i = p;
        tick();
        cmd_valid_i = 1'b0;
    endtask
    task automatic query(input logic [3:0] c, input logic [7:0] exp);
        cmd(c, 8'h00);
        chk(16'(resp_valid_o), 16'h0001);
        chk(16'(resp_data_o), 16'(exp));
    endtask
    task automatic settle(input logic [15:0] exp);
        idle();
        repeat (2) tick();
        chk(config_o, exp);
    endtask
    task automatic selftest(input logic [7:0] exp);
        cmd(`CMD_SELFTEST, 8'h00);
        for (int k = 0; k < 40 && resp_valid_o !== 1'b1; k++)
            tick();
        chk(16'(resp_valid_o), 16'h0001);
        chk(16'(resp_data_o), 16'(exp));
    endtask
    task automatic finish_test;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #100us;
        error_cnt++;
        finish_test();
    end
    initial
    begin
        repeat (16) tick();
        resetn_i = 1'b1;
        query(`CMD_SRE_QUERY, 8'h00);
        for (i = 0; i < 9; i++)
        begin
            cmd(`CMD_SRE_WRITE, pats[i]);
            query(`CMD_SRE_QUERY, pats[i] & 8'hbd);
        end
        for (i = 0; i < 8; i++)
        begin
            if (i == 1 || i == 6)
                continue;
            st = 8'h01 << i;
            cmd(`CMD_SRE_WRITE, 8'hbd ^ st);
            query(`CMD_STB_QUERY, st);
            query(`CMD_STB_QUERY, st);
            chk(16'(srq_o), 16'h0000);
            cmd(`CMD_SRE_WRITE, st);
            tick();
            chk(16'(srq_o), 16'h0001);
            query(`CMD_STB_QUERY, st | 8'h40);
        end
        poll = 1'b1;
        repeat (2) tick();
        chk(16'(request_service_flag), 16'h0001);
        st = 8'h00;
        repeat (2) tick();
        chk(16'(request_service_flag), 16'h0000);
        poll = 1'b0;
        for (i = 0; i < 4; i++)
        begin
            trig_source_i = 2'(i);
            cmd(`CMD_TRIGGER, 8'h00);
            chk(16'(trigger_o), 16'(i == 1));
        end
        cmd(`CMD_RECALL, 8'h00);
        settle(PRE_CFG);
        cmd(`CMD_RESET, 8'h00);
        chk(config_o, RST_CFG);
        tick();
        chk(16'(cancel_pending_o), 16'h0001);
        tick();
        chk(16'(cancel_opc_o), 16'h0001);
        cmd(`CMD_SAVE, 8'h00);
        cmd(`CMD_RECALL, 8'h05);
        settle(RST_CFG);
        cmd(`CMD_RECALL, 8'h00);
        settle(RST_CFG);
        selftest(8'h00);
        bad = 1'b1;
        selftest(8'h01);
        finish_test();
    end
endmodule
`default_nettype wire
